// file: logic/icm_input_curve_mapper.sv
module icm_input_curve_mapper
  import icm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = ICM_TICK_CYCLES
) (
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire icm_bus_req_type bus_req_i,
  output logic [ICM_DW-1:0]    reg_rdata_o,
  input  wire logic [15:0]     analog_in_first_i,
  input  wire logic [15:0]     analog_in_second_i,
  input  wire logic [1:0]      input_type_switch_i,
  input  wire logic [15:0]     pulse_freq_i,
  output logic [15:0]          phys_first_o,
  output logic [15:0]          phys_second_o,
  output logic [15:0]          phys_pulse_o
);

  icm_state_type s_q;
  icm_state_type s_d;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (r < lo) begin
      r = lo;
    end
    if (r > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // straight line through two point pairs; a flat or reversed span yields y0
  function automatic logic [15:0] interp(input logic [15:0] x,
                                         input logic [15:0] x0,
                                         input logic [15:0] x1,
                                         input logic [15:0] y0,
                                         input logic [15:0] y1);
    logic signed [33:0] num;
    logic signed [33:0] res;
    res = 34'(signed'({1'b0, y0}));
    if (x1 > x0) begin
      num = 34'(signed'({1'b0, x - x0})) *
            (34'(signed'({1'b0, y1})) - 34'(signed'({1'b0, y0})));
      res = res + num / 34'(signed'({1'b0, x1 - x0}));
    end
    return res[15:0];
  endfunction

  function automatic logic [15:0] full_scale(input logic [1:0] ch);
    return (ch == 2'd2) ? ICM_PULSE_FS : ICM_ANALOG_FS;
  endfunction

  // limit a written value to the range its register allows
  function automatic logic [15:0] limit_param(input logic [3:0] idx,
                                              input logic [15:0] v,
                                              input logic [15:0][15:0] p,
                                              input icm_mode_type md);
    logic [3:0]  base;
    logic [2:0]  ofs;
    logic [1:0]  ch;
    logic [15:0] r;
    base = 4'((idx - 4'd1) / 4'd5);
    ofs  = 3'((idx - 4'd1) % 4'd5);
    ch   = base[1:0];
    base = 4'(base * 4'd5 + 4'd1);
    r    = v;
    if (ofs == ICM_OFS_FILTER) begin
      r = clamp16(v, ICM_FILTER_MIN, ICM_FILTER_MAX);
    end else if (ofs == ICM_OFS_PMIN || ofs == ICM_OFS_PMAX) begin
      r = clamp16(v, 16'h0000, ICM_PHYS_MAX);
    end else if (md != ICM_MODE_INDEP) begin
      r = clamp16(v, 16'h0000, full_scale(2'(md) - 2'd1));
    end else if (ofs == ICM_OFS_MIN) begin
      r = clamp16(v, 16'h0000, p[base + 4'(ICM_OFS_MAX)]);
    end else begin
      r = clamp16(v, p[base], full_scale(ch));
    end
    return r;
  endfunction

  // parameter registers occupy one contiguous index range
  function automatic logic is_param(input logic [ICM_AW-1:0] a);
    return (a >= ICM_REG_FIRST_MIN) && (a <= ICM_REG_PULSE_FILTER);
  endfunction

  // physical value registers follow the confirm and active selector
  function automatic logic is_phys(input logic [ICM_AW-1:0] a);
    return (a >= ICM_REG_PHYS_FIRST) && (a <= ICM_REG_PHYS_PULSE);
  endfunction

  // only selector codes 0 to 3 exist
  function automatic logic sel_ok(input logic [15:0] v);
    return v <= 16'h0003;
  endfunction

  // first register index of a channel's group of five
  function automatic logic [3:0] group_base(input int unsigned c);
    return 4'(c * 5 + 1);
  endfunction

  // one filter step falls due every TICK_CYCLES clocks
  function automatic logic tick_due(input logic [31:0] t);
    return t >= 32'(TICK_CYCLES - 1);
  endfunction

  // free-running divider that paces the filter steps
  function automatic logic [31:0] next_tick(input logic [31:0] t);
    logic [31:0] r;
    r = t + 32'h0000_0001;
    if (tick_due(t)) begin
      r = 32'h0000_0000;
    end
    return r;
  endfunction

  // channel served by a nonlinear mode; the independent mode has none
  function automatic logic [1:0] mode_channel(input icm_mode_type md);
    logic [1:0] r;
    case (md)
      ICM_MODE_FIRST:  r = 2'd0;
      ICM_MODE_SECOND: r = 2'd1;
      ICM_MODE_PULSE:  r = 2'd2;
      default:         r = 2'd3;
    endcase
    return r;
  endfunction

  // a current input in 0.01 mA is halved onto the 0.01 V scale
  function automatic logic [15:0] front_end(input logic [15:0] v,
                                            input logic        is_current);
    logic [15:0] r;
    r = v;
    if (is_current) begin
      r = {1'b0, v[15:1]};
    end
    return r;
  endfunction

  // curve points loaded when a changed selector is committed
  function automatic logic [15:0][15:0] commit_defaults(input logic [15:0][15:0] p,
                                                        input logic [1:0]        sel);
    logic [15:0][15:0] r;
    r = p;
    if (sel == 2'd0) begin
      r = ICM_PARAM_RESET;
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (sel == 2'd3) begin
          r[ICM_NL_X_IDX[k]] = ICM_NL_PULSE_X[k];
        end else begin
          r[ICM_NL_X_IDX[k]] = ICM_NL_ANALOG_X[k];
        end
        r[ICM_NL_Y_IDX[k]] = ICM_NL_PHYS_Y[k];
      end
    end
    return r;
  endfunction

  // register writes; a selector above 3 is ignored, parameters are clamped
  function automatic icm_state_type apply_write(input icm_state_type   s,
                                                input icm_bus_req_type rq);
    icm_state_type r;
    r = s;
    if (rq.addr == ICM_REG_CURVE_SELECT) begin
      if (sel_ok(rq.wdata)) begin
        r.pend_sel = rq.wdata[1:0];
      end
    end else if (rq.addr == ICM_REG_CONFIRM) begin
      // an unchanged selector keeps the points the user has set
      if (s.pend_sel != 2'(s.mode)) begin
        r.mode   = icm_mode_type'(s.pend_sel);
        r.params = commit_defaults(s.params, s.pend_sel);
      end
    end else if (is_param(rq.addr)) begin
      r.params[rq.addr[3:0]] = limit_param(rq.addr[3:0],
                                           rq.wdata,
                                           s.params,
                                           s.mode);
    end
    return r;
  endfunction

  // read decode; unmapped indices answer zero
  function automatic logic [15:0] read_mux(input icm_state_type     s,
                                           input logic [ICM_AW-1:0] a);
    logic [15:0] r;
    r = 16'h0000;
    if (a == ICM_REG_CURVE_SELECT) begin
      r = {14'h0000, s.pend_sel};
    end else if (is_param(a)) begin
      r = s.params[a[3:0]];
    end else if (a == ICM_REG_ACTIVE_SEL) begin
      r = {14'h0000, 2'(s.mode)};
    end else if (is_phys(a)) begin
      r = s.phys[2'(a - ICM_REG_PHYS_FIRST)];
    end
    return r;
  endfunction

  // first-order low-pass step: acc + (x * 256 - acc) / tc
  // truncating division leaves up to tc-1 fraction lsbs of lag
  function automatic logic [23:0] filter_step(input logic [15:0] x,
                                              input logic [23:0] acc,
                                              input logic [15:0] tc_raw);
    logic [15:0]        tcv;
    logic signed [25:0] xs;
    logic signed [25:0] acs;
    logic signed [25:0] diff;
    logic signed [25:0] stp;
    tcv  = (tc_raw == 16'h0000) ? ICM_FILTER_MIN : tc_raw;
    xs   = 26'(signed'({2'b00, x, 8'h00}));
    acs  = 26'(signed'({2'b00, acc}));
    diff = xs - acs;
    stp  = diff / 26'(signed'({10'h000, tcv}));
    return 24'(acs + stp);
  endfunction

  // independent curve of one channel from its own group of five
  function automatic logic [15:0] map_indep(input logic [15:0]       x,
                                            input logic [15:0][15:0] p,
                                            input logic [3:0]        gb);
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] xe;
    lo = p[gb];
    hi = p[gb + 4'(ICM_OFS_MAX)];
    xe = clamp16(x, lo, hi);
    return interp(xe,
                  lo,
                  hi,
                  p[gb + 4'(ICM_OFS_PMIN)],
                  p[gb + 4'(ICM_OFS_PMAX)]);
  endfunction

  // six-point curve; segments assume rising inputs, the lowest bracket wins
  function automatic logic [15:0] map_nonlin(input logic [15:0]       x,
                                             input logic [15:0][15:0] p);
    logic [15:0] xe;
    logic [15:0] r;
    xe = clamp16(x, p[ICM_NL_X_IDX[0]], p[ICM_NL_X_IDX[5]]);
    r  = p[ICM_NL_Y_IDX[0]];
    for (int k = 4; k >= 0; k--) begin
      if (xe >= p[ICM_NL_X_IDX[k]] && xe <= p[ICM_NL_X_IDX[k + 1]]) begin
        r = interp(xe,
                   p[ICM_NL_X_IDX[k]],
                   p[ICM_NL_X_IDX[k + 1]],
                   p[ICM_NL_Y_IDX[k]],
                   p[ICM_NL_Y_IDX[k + 1]]);
      end
    end
    return r;
  endfunction

  logic [2:0][15:0] x_raw;
  logic [15:0]      x_filt;
  logic [3:0]       fidx;
  logic [3:0]       gbase;
  logic [1:0]       nl_ch;
  logic             tick_now;

  always_comb begin
    s_d      = s_q;
    x_filt   = 16'h0000;
    fidx     = 4'h0;
    gbase    = 4'h0;
    nl_ch    = mode_channel(s_q.mode);
    tick_now = tick_due(s_q.tick);

    x_raw[0] = front_end(analog_in_first_i, input_type_switch_i[0]);
    x_raw[1] = front_end(analog_in_second_i, input_type_switch_i[1]);
    x_raw[2] = pulse_freq_i;

    if (bus_req_i.wr) begin
      s_d = apply_write(s_q, bus_req_i);
    end

    // read data stand for one cycle only, zero otherwise
    s_d.rdata = 16'h0000;
    if (bus_req_i.rd) begin
      s_d.rdata = read_mux(s_q, bus_req_i.addr);
    end

    // one filter step per 10 ms tick on every channel
    s_d.tick = next_tick(s_q.tick);
    if (tick_now) begin
      for (int c = 0; c < 3; c++) begin
        fidx       = group_base(c) + 4'(ICM_OFS_FILTER);
        s_d.acc[c] = filter_step(x_raw[c], s_q.acc[c], s_q.params[fidx]);
      end
    end

    // the filter runs ahead of the clamp so limits act on settled values
    for (int c = 0; c < 3; c++) begin
      x_filt = s_q.acc[c][ICM_FRAC_BITS +: 16];
      gbase  = group_base(c);
      if (s_q.mode == ICM_MODE_INDEP) begin
        s_d.phys[c] = map_indep(x_filt, s_q.params, gbase);
      end else if (2'(c) != nl_ch) begin
        s_d.phys[c] = 16'h0000;
      end else begin
        s_d.phys[c] = map_nonlin(x_filt, s_q.params);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q          <= '0;
      s_q.params   <= ICM_PARAM_RESET;
      s_q.mode     <= ICM_MODE_INDEP;
      s_q.pend_sel <= 2'd0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o   = s_q.rdata;
  assign phys_first_o  = s_q.phys[0];
  assign phys_second_o = s_q.phys[1];
  assign phys_pulse_o  = s_q.phys[2];

endmodule // icm_input_curve_mapper

// file: logic/icm_pkg.sv
package icm_pkg;

  localparam int unsigned ICM_DW = 16;
  localparam int unsigned ICM_AW = 5;

  // register indices, one 16-bit register each
  localparam logic [4:0] ICM_REG_CURVE_SELECT = 5'h00;
  localparam logic [4:0] ICM_REG_FIRST_MIN    = 5'h01;
  localparam logic [4:0] ICM_REG_PULSE_FILTER = 5'h0f;
  localparam logic [4:0] ICM_REG_CONFIRM      = 5'h10;
  localparam logic [4:0] ICM_REG_ACTIVE_SEL   = 5'h11;
  localparam logic [4:0] ICM_REG_PHYS_FIRST   = 5'h12;
  localparam logic [4:0] ICM_REG_PHYS_SECOND  = 5'h13;
  localparam logic [4:0] ICM_REG_PHYS_PULSE   = 5'h14;

  // position of a parameter inside a channel group of five
  localparam logic [2:0] ICM_OFS_MIN    = 3'h0;
  localparam logic [2:0] ICM_OFS_PMIN   = 3'h1;
  localparam logic [2:0] ICM_OFS_MAX    = 3'h2;
  localparam logic [2:0] ICM_OFS_PMAX   = 3'h3;
  localparam logic [2:0] ICM_OFS_FILTER = 3'h4;

  // units: analog 0.01 V, pulse 0.01 kHz, physical 0.1 %, filter 0.01 s
  localparam logic [15:0] ICM_ANALOG_FS  = 16'h03e8;
  localparam logic [15:0] ICM_PULSE_FS   = 16'h1388;
  localparam logic [15:0] ICM_PHYS_MAX   = 16'h03e8;
  localparam logic [15:0] ICM_FILTER_MIN = 16'h0001;
  localparam logic [15:0] ICM_FILTER_MAX = 16'h1388;

  // reset values of parameter registers, index 15 first, index 0 unused
  localparam logic [15:0][15:0] ICM_PARAM_RESET = {
    16'h0005, 16'h03e8, 16'h1388, 16'h0000, 16'h0000,
    16'h0005, 16'h03e8, 16'h03e8, 16'h0000, 16'h000a,
    16'h0005, 16'h03e8, 16'h03e8, 16'h0000, 16'h000a,
    16'h0000};

  // six curve points of nonlinear mode: input and physical register indices
  localparam logic [5:0][3:0] ICM_NL_X_IDX = {4'hd, 4'hb, 4'h8, 4'h6, 4'h3, 4'h1};
  localparam logic [5:0][3:0] ICM_NL_Y_IDX = {4'he, 4'hc, 4'h9, 4'h7, 4'h4, 4'h2};
  localparam logic [5:0][15:0] ICM_NL_ANALOG_X = {
    16'h03e8, 16'h0320, 16'h0258, 16'h0190, 16'h00c8, 16'h0000};
  localparam logic [5:0][15:0] ICM_NL_PULSE_X = {
    16'h1388, 16'h0fa0, 16'h0bb8, 16'h07d0, 16'h03e8, 16'h0000};
  localparam logic [5:0][15:0] ICM_NL_PHYS_Y = {
    16'h03e8, 16'h0320, 16'h0258, 16'h0190, 16'h00c8, 16'h0000};

  // filter step time: one filter unit of 10 ms
  localparam int unsigned ICM_CLK_PERIOD_NS  = 40;
  localparam int unsigned ICM_FILTER_UNIT_NS = 10_000_000;
  localparam int unsigned ICM_TICK_CYCLES    = ICM_FILTER_UNIT_NS / ICM_CLK_PERIOD_NS;
  localparam int unsigned ICM_FRAC_BITS      = 8;

  typedef enum logic [1:0] {
    ICM_MODE_INDEP,
    ICM_MODE_FIRST,
    ICM_MODE_SECOND,
    ICM_MODE_PULSE
  } icm_mode_type;

  typedef struct packed {
    logic [ICM_AW-1:0] addr;
    logic [ICM_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } icm_bus_req_type;

  typedef struct packed {
    logic [15:0][15:0] params;
    logic [1:0]        pend_sel;
    icm_mode_type      mode;
    logic [31:0]       tick;
    logic [2:0][23:0]  acc;
    logic [2:0][15:0]  phys;
    logic [15:0]       rdata;
  } icm_state_type;

endpackage

// file: sim/icm_source_model.sv
module icm_source_model
  import icm_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] set_first_i,
  input  wire logic [15:0] set_second_i,
  input  wire logic [15:0] set_pulse_i,
  input  wire logic [1:0]  set_type_i,
  output logic [15:0]      first_o = '0,
  output logic [15:0]      second_o = '0,
  output logic [15:0]      pulse_o = '0,
  output logic [1:0]       type_o = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // sources are levels, so a new value only appears after the edge
  always @(posedge clk_sys_i) begin
    first_o  <= set_first_i;
    second_o <= set_second_i;
    pulse_o  <= set_pulse_i;
    type_o   <= set_type_i;
  end
endmodule // icm_source_model

// file: sim/icm_checker.sv
module icm_checker
  import icm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = ICM_TICK_CYCLES
) (
  input wire logic            clk_sys_i,
  input wire logic            rst_i,
  input wire icm_bus_req_type bus_req_i,
  input wire logic [15:0]     reg_rdata_o,
  input wire logic [15:0]     phys_first_o,
  input wire logic [15:0]     phys_second_o,
  input wire logic [15:0]     phys_pulse_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pend_q;
  logic [1:0] act_q;
  logic [5:0] rq;
  assign rq = {bus_req_i.rd, bus_req_i.addr};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // shadow of the selector, rebuilt from the bus writes alone
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 2'h0;
      act_q  <= 2'h0;
    end else if (bus_req_i.wr) begin
      if (bus_req_i.addr == ICM_REG_CURVE_SELECT && bus_req_i.wdata <= 16'h3)
        pend_q <= bus_req_i.wdata[1:0];
      if (bus_req_i.addr == ICM_REG_CONFIRM)
        act_q <= pend_q;
    end
  end
  sel_range_a: assert property ($past(rq) == {1'b1, ICM_REG_CURVE_SELECT}
    |-> reg_rdata_o == {14'h0, $past(pend_q)}) else $error("pending selector wrong");
  act_track_a: assert property ($past(rq) == {1'b1, ICM_REG_ACTIVE_SEL}
    |-> reg_rdata_o == {14'h0, $past(act_q)}) else $error("active selector wrong");
  others_zero_a: assert property ($stable(act_q) [*8] ##0 act_q != 2'h0
    |-> (act_q == 2'h1 || phys_first_o == 16'h0) && (act_q == 2'h2 || phys_second_o == 16'h0)
    && (act_q == 2'h3 || phys_pulse_o == 16'h0)) else $error("unselected channel not zero");
  phys_range_a: assert property (phys_first_o <= ICM_PHYS_MAX && phys_second_o <= ICM_PHYS_MAX
    && phys_pulse_o <= ICM_PHYS_MAX) else $error("physical value above full scale");
  filter_range_a: assert property ($past(rq) inside {6'h25, 6'h2a, 6'h2f}
    |-> reg_rdata_o inside {[ICM_FILTER_MIN:ICM_FILTER_MAX]}) else $error("filter out of range");
  max_range_a: assert property ($past(rq) == 6'h23 && $past(act_q) != 2'h3
    |-> reg_rdata_o <= ICM_ANALOG_FS) else $error("analog max point above full scale");
  pulse_max_a: assert property ($past(rq) == 6'h2d
    |-> reg_rdata_o <= ICM_PULSE_FS) else $error("pulse max point above full scale");
  phys_read_a: assert property ($past(rq) == {1'b1, ICM_REG_PHYS_FIRST}
    |-> reg_rdata_o == $past(phys_first_o)) else $error("physical read mismatch");
endmodule // icm_checker
bind icm_input_curve_mapper icm_checker #(.TICK_CYCLES(TICK_CYCLES)) icm_checker_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_req_i(bus_req_i), .reg_rdata_o(reg_rdata_o),
  .phys_first_o(phys_first_o), .phys_second_o(phys_second_o), .phys_pulse_o(phys_pulse_o));

// file: sim/input_curve_mapper_tb.sv
module input_curve_mapper_tb
  import icm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCK = 4;
  localparam logic [4:0] CA [11] = '{3, 3, 1, 2, 2, 4, 5, 6, 10, 15, 13};
  localparam logic [15:0] CD [11] = '{2000, 700, 200, 2000, 100, 600, 1, 0, 1, 0, 16'hffff};
  localparam logic [15:0] CE [11] = '{1000, 700, 200, 1000, 100, 600, 1, 0, 1, 1, 5000};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  icm_bus_req_type req = '0;
  logic [15:0] pf, ps, pp, rdv, a1, a2, fq, s1 = '0, s2 = '0, sq = '0, x1, x2, xp;
  logic [1:0] ty, st = '0, t;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  icm_source_model icm_source_model_i (.clk_sys_i(clk_sys_i), .set_first_i(s1),
    .set_second_i(s2), .set_pulse_i(sq), .set_type_i(st), .first_o(a1), .second_o(a2),
    .pulse_o(fq), .type_o(ty));
  icm_input_curve_mapper #(.TICK_CYCLES(TCK)) icm_input_curve_mapper_i (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .bus_req_i(req), .reg_rdata_o(rdv), .analog_in_first_i(a1),
    .analog_in_second_i(a2), .input_type_switch_i(ty), .pulse_freq_i(fq),
    .phys_first_o(pf), .phys_second_o(ps), .phys_pulse_o(pp));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // a gap cycle after each strobe keeps req to one assignment per step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
    req <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    req <= '0;
    #1 chk($sformatf("reg %h", a), rdv, e);
    @(posedge clk_sys_i);
  endtask
  function automatic logic [15:0] lin(int x, int x0, int x1, int y0, int y1);
    x = x < x0 ? x0 : x > x1 ? x1 : x;
    return 16'(y0 + (x - x0) * (y1 - y0) / (x1 - x0));
  endfunction
  task automatic ph(input logic [15:0] e1, input logic [15:0] e2, input logic [15:0] ep);
    repeat (3 * TCK + 4) @(posedge clk_sys_i);
    #1 chk("phys_first", pf, e1);
    chk("phys_second", ps, e2);
    chk("phys_pulse", pp, ep);
    @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(22));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int i = 1; i < 16; i++) rc(5'(i), ICM_PARAM_RESET[i]);
    rc(5'h1f, 16'h0);
    for (int i = 0; i < 5; i++) begin
      wr(ICM_REG_CURVE_SELECT, 16'(i));
      rc(ICM_REG_CURVE_SELECT, i < 4 ? 16'(i) : 16'h3);
    end
    wr(ICM_REG_CURVE_SELECT, 16'h0);
    $display("reset and selector test done");
    for (int i = 0; i < 11; i++) begin
      wr(CA[i], CD[i]);
      rc(CA[i], CE[i]);
    end
    for (int i = 0; i < 24; i++) begin
      {x1, x2, xp, t} = {16'($urandom_range(0, 2000)), 16'($urandom_range(0, 2000)),
                         16'(5 * $urandom_range(0, 1000)), 2'($urandom_range(0, 3))};
      if (i == 0) {x1, x2, xp, t} = '0;
      if (i == 1) {x1, x2, xp, t} = {16'h07d0, 16'h07d0, 16'h1770, 2'h0};
      {s1, s2, sq, st} <= {x1, x2, xp, t};
      ph(lin(t[0] ? x1 >> 1 : x1, 200, 700, 100, 600), lin(t[1] ? x2 >> 1 : x2, 0, 1000, 0,
         1000), lin(xp, 0, 5000, 0, 1000));
      rc(ICM_REG_PHYS_FIRST, lin(t[0] ? x1 >> 1 : x1, 200, 700, 100, 600));
    end
    $display("independent curve test done");
    {s1, s2, sq, st} <= {16'd300, 16'd300, 16'd1500, 2'h0};
    for (int m = 1; m < 4; m++) begin
      wr(ICM_REG_CURVE_SELECT, 16'(m));
      wr(ICM_REG_CONFIRM, 16'h0);
      rc(ICM_REG_ACTIVE_SEL, 16'(m));
      for (int i = 0; i < 6; i++) begin
        rc(ICM_NL_X_IDX[i], m == 3 ? ICM_NL_PULSE_X[i] : ICM_NL_ANALOG_X[i]);
        rc(ICM_NL_Y_IDX[i], ICM_NL_PHYS_Y[i]);
      end
      wr(5'(5 * m), 16'h1);
      wr(ICM_NL_Y_IDX[1], 16'h0064);
      // second point lowered, so the bracket interpolation is no identity
      ph(m == 1 ? 16'd250 : 16'd0, m == 2 ? 16'd250 : 16'd0, m == 3 ? 16'd250 : 16'd0);
      wr(ICM_REG_CONFIRM, 16'h0);
      rc(ICM_NL_Y_IDX[1], 16'h0064);
    end
    wr(ICM_REG_CURVE_SELECT, 16'h0);
    wr(ICM_REG_CONFIRM, 16'h0);
    rc(5'h03, ICM_PARAM_RESET[3]);
    $display("nonlinear curve test done");
    report_and_stop();
  end
endmodule // input_curve_mapper_tb
